// >>> bsl_pkg.sv
// Constants and types shared by the boot source and security loader
package bsl_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_MHZ = 100;
	localparam int RST_PROC_US = 15;
	localparam int RST_PROC_CYC = RST_PROC_US * CLK_MHZ;
	localparam int RATIO_EDGE = 2;
	localparam int SPI_SCLK_KHZ = 2500;
	localparam int SPI_HALF_CYC = (CLK_MHZ * 1000) / (2 * SPI_SCLK_KHZ);
	localparam int LINK_DLY_NS = 200;
	localparam int LINK_DLY_CYC = (LINK_DLY_NS * CLK_MHZ + 999) / 1000;

	// ********************************
	// OTP layout
	// ********************************
	localparam int OTP_ROWS = 2048;
	localparam int OTP_AW = 11;
	localparam int OTP_DW = 32;
	localparam logic [10:0] SEC_ROW = 11'h7FF;
	localparam logic [10:0] COPY_LAST = 11'h7FE;
	localparam logic [10:0] ROW_ZERO = 11'h000;

	// Security word bit positions
	localparam int SEC_JTAG_DIS = 0;
	localparam int SEC_LINK_DIS = 1;
	localparam int SEC_GDBG_DIS = 2;
	localparam int SEC_MLOCK = 3;
	localparam int SEC_BOOT = 5;
	localparam int SEC_SLOCK_LO = 6;
	localparam int SEC_SLOCK_N = 4;

	// SPI flash read command with address zero
	localparam logic [31:0] SPI_READ_CMD = 32'h0300_0000;

	// Boot select codes on the three select pins
	localparam logic [2:0] SEL_LINKB = 3'h2;
	localparam logic [2:0] SEL_SPI0 = 3'h3;
	localparam logic [2:0] SEL_CE0 = 3'h6;
	localparam logic [2:0] SEL_SPI2 = 3'h7;

	typedef struct packed {
		logic [3:0] sector_lock;
		logic secure_boot;
		logic master_lock;
		logic gdbg_dis;
		logic link_dis;
		logic jtag_dis;
	} bsl_sec_t;

	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_LINKB = 3'h1,
		SRC_SPI = 3'h2,
		SRC_CE0 = 3'h3,
		SRC_OTP = 3'h4
	} bsl_src_t;

	typedef enum logic [2:0] {
		ST_RST = 3'h0,
		ST_SEC_RD = 3'h1,
		ST_SEC_WT = 3'h3,
		ST_SEC_CAP = 3'h2,
		ST_CP_RD = 3'h6,
		ST_CP_WT = 3'h7,
		ST_CP_WR = 3'h5,
		ST_BOOT = 3'h4
	} bsl_state_t;

endpackage

// >>> bsl_loader.sv
// Boot sequencer: reset process, OTP security load and copy, boot source, SPI and link start
//
// Summary of operation
// - Pins stay high impedance while reset held
// - Pull resistors enabled when reset process ends
// - Clock ratio taken from two select pins
// - Three boot-select pins choose each tile source
// - Select x00 waits for debug port; x01 reserved
// - 010 link B, 011 SPI; tile one via
// - Code 110: links enabled, boot channel end
// - Code 111: both tiles boot from SPI
// - Secure bit forces boot from OTP memory
// - SPI master drives clock at fixed rate
// - SPI pins fixed, never reassigned
// - Link B enabled about 200 ns later
// - Link pull-downs off, lines 16/17 low
// - Watch lines 19/20; peer holds them low
// - Security word loaded from OTP first
// - Remaining OTP copied to SRAM, run first
// - OTP is 2k rows of 32 bits
// - Secure boot bypasses ROM, starts at zero
// - Debug port access blocked when disabled
// - Switch access refused when link disabled
// - Debug sync pin ignored when disabled
// - Master lock and four sector locks
`timescale 1ns/100ps
module bsl_loader (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic clock_ratio_sel_lo,
	input wire logic clock_ratio_sel_hi,
	input wire logic [2:0] boot_sel_pins,
	input wire logic [31:0] otp_rd_data,
	output logic otp_rd_en,
	output logic [10:0] otp_rd_addr,
	output logic sram_wr_en,
	output logic [10:0] sram_addr,
	output logic [31:0] sram_wr_data,
	output logic gpio_pull_en,
	output logic [1:0] clk_ratio,
	output bsl_pkg::bsl_src_t tile_zero_src,
	output bsl_pkg::bsl_src_t tile_one_src,
	output logic rom_bypass,
	output logic loader_done,
	input wire logic spi_boot_miso_pin,
	output logic spi_boot_select_pin,
	output logic spi_boot_clock_pin,
	output logic spi_boot_mosi_pin,
	output logic spi_pins_oe,
	output logic [31:0] spi_word,
	output logic spi_word_valid,
	output logic link_b_en,
	output logic int_links_en,
	output logic link_pulldown_en,
	output logic link_line_16,
	output logic link_line_17,
	output logic link_lines_oe,
	input wire logic link_line_19,
	input wire logic link_line_20,
	output logic link_traffic,
	output logic jtag_access_en,
	input wire logic sw_access_req,
	output logic sw_access_grant,
	input wire logic debug_sync_n,
	output logic debug_req,
	input wire logic otp_ext_req,
	input wire logic [1:0] otp_ext_sector,
	output logic otp_ext_grant
);
	import bsl_pkg::*;

	localparam logic [10:0] RP_LAST = 11'(RST_PROC_CYC - 1);
	localparam logic [10:0] RP_RATIO = 11'(RATIO_EDGE);
	localparam logic [4:0] SPI_LAST = 5'(SPI_HALF_CYC - 1);
	localparam logic [4:0] LINK_LAST = 5'(LINK_DLY_CYC - 1);

	bsl_state_t state_r;
	logic [10:0] rp_cnt_r;
	logic [10:0] cp_addr_r;
	bsl_sec_t sec_r;
	logic [2:0] boot_sel_r;
	logic [2:0] sel_q1, sel_q2;
	logic [1:0] ratio_q1, ratio_q2;
	logic miso_q1, miso_q2;
	logic dbg_q1, dbg_q2;
	logic [4:0] div_cnt_r;
	logic [4:0] bit_cnt_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic cmd_done_r;
	logic [4:0] dly_cnt_r;
	logic tr_q1, tr_q2, tr_q3;
	logic lr_q1, link_rst_n;
	logic len_q1, len_q2;
	logic l19_q1, l19_q2, l20_q1, l20_q2;
	logic seen_r, traffic_tgl_r;
	logic spi_want, link_want;

	// ********************************
	// Helpers
	// ********************************

	// Maps the latched select code and secure bit to one tile's source
	function automatic bsl_src_t decode_src(input logic [2:0] sel, input logic secure,
		input logic tile1);
		bsl_src_t src;
		src = SRC_NONE;
		if (secure) begin
			src = SRC_OTP;
		end else begin
			casez (sel)
				3'b?00: src = SRC_NONE;
				3'b?01: src = SRC_NONE;
				SEL_LINKB: src = tile1 ? SRC_CE0 : SRC_LINKB;
				SEL_SPI0: src = tile1 ? SRC_CE0 : SRC_SPI;
				SEL_CE0: src = SRC_CE0;
				SEL_SPI2: src = SRC_SPI;
				default: src = SRC_NONE;
			endcase
		end
		return src;
	endfunction

	// Unpacks the security word read from the reserved top row
	function automatic bsl_sec_t unpack_sec(input logic [31:0] w);
		bsl_sec_t s;
		s.sector_lock = w[SEC_SLOCK_LO +: SEC_SLOCK_N];
		s.secure_boot = w[SEC_BOOT];
		s.master_lock = w[SEC_MLOCK];
		s.gdbg_dis = w[SEC_GDBG_DIS];
		s.link_dis = w[SEC_LINK_DIS];
		s.jtag_dis = w[SEC_JTAG_DIS];
		return s;
	endfunction

	// ********************************
	// Pin synchronisers
	// ********************************

	// Pins are asynchronous to clk; only the second stage is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q1 <= 3'h0;
			sel_q2 <= 3'h0;
			ratio_q1 <= 2'h0;
			ratio_q2 <= 2'h0;
			miso_q1 <= 1'b0;
			miso_q2 <= 1'b0;
			dbg_q1 <= 1'b1;
			dbg_q2 <= 1'b1;
		end else begin
			sel_q1 <= boot_sel_pins;
			sel_q2 <= sel_q1;
			ratio_q1 <= {clock_ratio_sel_hi, clock_ratio_sel_lo};
			ratio_q2 <= ratio_q1;
			miso_q1 <= spi_boot_miso_pin;
			miso_q2 <= miso_q1;
			dbg_q1 <= debug_sync_n;
			dbg_q2 <= dbg_q1;
		end
	end

	// ********************************
	// Sequencer
	// ********************************

	// Main load sequence; OTP reads take one cycle of latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_RST;
		end else begin
			case (state_r)
				ST_RST: if (rp_cnt_r == RP_LAST) state_r <= ST_SEC_RD;
				ST_SEC_RD: state_r <= ST_SEC_WT;
				ST_SEC_WT: state_r <= ST_SEC_CAP;
				ST_SEC_CAP: state_r <= ST_CP_RD;
				ST_CP_RD: state_r <= ST_CP_WT;
				ST_CP_WT: state_r <= ST_CP_WR;
				ST_CP_WR: state_r <= (cp_addr_r == COPY_LAST) ? ST_BOOT : ST_CP_RD;
				ST_BOOT: state_r <= ST_BOOT;
				default: state_r <= ST_RST;
			endcase
		end
	end

	// Reset process timer, counts from the first edge after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rp_cnt_r <= 11'h000;
		end else if (state_r == ST_RST) begin
			rp_cnt_r <= rp_cnt_r + 11'h001;
		end
	end

	// Pulls come on with the end of the reset process, held until reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_pull_en <= 1'b0;
		end else if (state_r == ST_RST && rp_cnt_r == RP_LAST) begin
			gpio_pull_en <= 1'b1;
		end
	end

	// Ratio latched on the third edge, select code at end of process
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_ratio <= 2'h0;
			boot_sel_r <= 3'h0;
		end else if (state_r == ST_RST) begin
			if (rp_cnt_r == RP_RATIO) clk_ratio <= ratio_q2;
			if (rp_cnt_r == RP_LAST) boot_sel_r <= sel_q2;
		end
	end

	// OTP read port; the top row holds the security word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			otp_rd_en <= 1'b0;
			otp_rd_addr <= ROW_ZERO;
		end else begin
			otp_rd_en <= (state_r == ST_SEC_RD) || (state_r == ST_CP_RD);
			otp_rd_addr <= (state_r == ST_SEC_RD) ? SEC_ROW : cp_addr_r;
		end
	end

	// Security word capture; stays in force until the next reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_r <= '0;
		end else if (state_r == ST_SEC_CAP) begin
			sec_r <= unpack_sec(otp_rd_data);
		end
	end

	// Image copy into SRAM, one row every three cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_addr_r <= ROW_ZERO;
			sram_wr_en <= 1'b0;
			sram_addr <= ROW_ZERO;
			sram_wr_data <= 32'h0000_0000;
		end else begin
			sram_wr_en <= (state_r == ST_CP_WR);
			if (state_r == ST_CP_WR) begin
				sram_addr <= cp_addr_r;
				sram_wr_data <= otp_rd_data;
				cp_addr_r <= cp_addr_r + 11'h001;
			end
		end
	end

	// Boot decision taken once, as the copy finishes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tile_zero_src <= SRC_NONE;
			tile_one_src <= SRC_NONE;
			rom_bypass <= 1'b0;
			loader_done <= 1'b0;
		end else if (state_r == ST_CP_WR && cp_addr_r == COPY_LAST) begin
			tile_zero_src <= decode_src(boot_sel_r, sec_r.secure_boot, 1'b0);
			tile_one_src <= decode_src(boot_sel_r, sec_r.secure_boot, 1'b1);
			rom_bypass <= sec_r.secure_boot;
			loader_done <= 1'b1;
		end
	end

	// ********************************
	// Security gating
	// ********************************

	// Everything stays denied until loader_done, after the image copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jtag_access_en <= 1'b0;
			sw_access_grant <= 1'b0;
			debug_req <= 1'b0;
			otp_ext_grant <= 1'b0;
		end else begin
			jtag_access_en <= loader_done && !sec_r.jtag_dis;
			sw_access_grant <= sw_access_req && loader_done && !sec_r.link_dis;
			debug_req <= !dbg_q2 && loader_done && !sec_r.gdbg_dis;
			otp_ext_grant <= otp_ext_req && loader_done && !sec_r.master_lock &&
				!sec_r.sector_lock[otp_ext_sector];
		end
	end

	// ********************************
	// SPI boot master
	// ********************************

	assign spi_want = loader_done && (tile_zero_src == SRC_SPI || tile_one_src == SRC_SPI);

	// Mode 0 master on fixed pins; sends a read at zero then streams words
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spi_pins_oe <= 1'b0;
			spi_boot_select_pin <= 1'b1;
			spi_boot_clock_pin <= 1'b0;
			spi_boot_mosi_pin <= 1'b0;
			div_cnt_r <= 5'h00;
			bit_cnt_r <= 5'h00;
			tx_r <= SPI_READ_CMD;
			rx_r <= 32'h0000_0000;
			cmd_done_r <= 1'b0;
			spi_word <= 32'h0000_0000;
			spi_word_valid <= 1'b0;
		end else begin
			spi_word_valid <= 1'b0;
			if (spi_want && !spi_pins_oe) begin
				spi_pins_oe <= 1'b1;
				spi_boot_select_pin <= 1'b0;
				spi_boot_mosi_pin <= SPI_READ_CMD[31];
			end else if (spi_pins_oe) begin
				if (div_cnt_r == SPI_LAST) begin
					div_cnt_r <= 5'h00;
					spi_boot_clock_pin <= !spi_boot_clock_pin;
					if (!spi_boot_clock_pin) begin
						rx_r <= {rx_r[30:0], miso_q2};
						bit_cnt_r <= bit_cnt_r + 5'h01;
						if (bit_cnt_r == 5'h1F) begin
							cmd_done_r <= 1'b1;
							if (cmd_done_r) begin
								spi_word <= {rx_r[30:0], miso_q2};
								spi_word_valid <= 1'b1;
							end
						end
					end else begin
						tx_r <= {tx_r[30:0], 1'b0};
						spi_boot_mosi_pin <= tx_r[30];
					end
				end else begin
					div_cnt_r <= div_cnt_r + 5'h01;
				end
			end
		end
	end

	// ********************************
	// Link boot, clk side
	// ********************************

	assign link_want = loader_done && (tile_zero_src == SRC_LINKB || tile_zero_src == SRC_CE0);

	// Link B comes up a fixed delay after the boot decision
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_cnt_r <= 5'h00;
			link_b_en <= 1'b0;
			int_links_en <= 1'b0;
		end else if (link_want && !link_b_en) begin
			dly_cnt_r <= dly_cnt_r + 5'h01;
			if (dly_cnt_r == LINK_LAST) begin
				link_b_en <= 1'b1;
				int_links_en <= (tile_zero_src == SRC_CE0);
			end
		end
	end

	// Pull-downs on the link lines drop once the link owns them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_pulldown_en <= 1'b0;
		end else begin
			link_pulldown_en <= gpio_pull_en && !link_b_en;
		end
	end

	// Traffic event returns as a toggle; sticky once seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tr_q1 <= 1'b0;
			tr_q2 <= 1'b0;
			tr_q3 <= 1'b0;
			link_traffic <= 1'b0;
		end else begin
			tr_q1 <= traffic_tgl_r;
			tr_q2 <= tr_q1;
			tr_q3 <= tr_q2;
			if (tr_q2 != tr_q3) link_traffic <= 1'b1;
		end
	end

	// ********************************
	// Link boot, link_clk side
	// ********************************

	// Local reset: asserts at once, releases on link_clk
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lr_q1 <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			lr_q1 <= 1'b1;
			link_rst_n <= lr_q1;
		end
	end

	// Enable level and line pins enter through two stages each
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			len_q1 <= 1'b0;
			len_q2 <= 1'b0;
			l19_q1 <= 1'b0;
			l19_q2 <= 1'b0;
			l20_q1 <= 1'b0;
			l20_q2 <= 1'b0;
		end else begin
			len_q1 <= link_b_en;
			len_q2 <= len_q1;
			l19_q1 <= link_line_19;
			l19_q2 <= l19_q1;
			l20_q1 <= link_line_20;
			l20_q2 <= l20_q1;
		end
	end

	// Idle link drives 16/17 low; only enabled lines are driven
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_lines_oe <= 1'b0;
			link_line_16 <= 1'b0;
			link_line_17 <= 1'b0;
		end else begin
			link_lines_oe <= len_q2;
			link_line_16 <= 1'b0;
			link_line_17 <= 1'b0;
		end
	end

	// First high on 19 or 20 is boot traffic; the peer keeps them low before
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			seen_r <= 1'b0;
			traffic_tgl_r <= 1'b0;
		end else if (len_q2 && (l19_q2 || l20_q2) && !seen_r) begin
			seen_r <= 1'b1;
			traffic_tgl_r <= !traffic_tgl_r;
		end
	end

	// ********************************
	// Assertions
	// ********************************

	sequence s_sec_fetch;
		(state_r == ST_SEC_RD) ##1 (otp_rd_en && otp_rd_addr == SEC_ROW);
	endsequence

	sequence s_copy_start;
		(state_r == ST_CP_RD) ##1 (otp_rd_en && otp_rd_addr == ROW_ZERO);
	endsequence

	a_pins_in_reset: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_RST |-> !spi_pins_oe && !gpio_pull_en && !link_b_en)
		else $error("pin driven or pulled during reset process");
	a_pull_timing: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gpio_pull_en) |-> $past(state_r) == ST_RST && $past(rp_cnt_r) == RP_LAST)
		else $error("pull enable not at end of reset process");
	a_ratio_held: assert property (@(posedge clk) disable iff (!rst_n)
		state_r != ST_RST |=> $stable(clk_ratio))
		else $error("clock ratio changed after reset process");
	a_debug_wait: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(loader_done) && boot_sel_r[1:0] == 2'b00 && !sec_r.secure_boot
		|-> tile_zero_src == SRC_NONE && tile_one_src == SRC_NONE)
		else $error("boot source chosen in debug wait code");
	a_link_code: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(loader_done) && boot_sel_r == SEL_LINKB && !sec_r.secure_boot
		|-> tile_zero_src == SRC_LINKB && tile_one_src == SRC_CE0)
		else $error("link boot code decoded wrongly");
	a_spi_both: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(loader_done) && boot_sel_r == SEL_SPI2 && !sec_r.secure_boot
		|-> tile_zero_src == SRC_SPI && tile_one_src == SRC_SPI)
		else $error("dual SPI code decoded wrongly");
	a_otp_override: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(loader_done) && sec_r.secure_boot
		|-> tile_zero_src == SRC_OTP && tile_one_src == SRC_OTP && rom_bypass)
		else $error("secure boot did not force OTP");
	a_sclk_rate: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(spi_boot_clock_pin) |-> $past(div_cnt_r) == SPI_LAST && spi_pins_oe)
		else $error("SPI clock edge off its divider");
	a_link_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(link_b_en) |-> $past(dly_cnt_r) == LINK_LAST)
		else $error("link enabled at wrong delay");
	a_pulldown_off: assert property (@(posedge clk) disable iff (!rst_n)
		link_b_en |=> !link_pulldown_en)
		else $error("link pull-down left on");
	a_sec_first: assert property (@(posedge clk) disable iff (!rst_n)
		s_sec_fetch |=> ##1 s_copy_start)
		else $error("copy did not follow security load");
	a_copy_step: assert property (@(posedge clk) disable iff (!rst_n)
		sram_wr_en && sram_addr != COPY_LAST
		|-> ##3 (sram_wr_en && sram_addr == $past(sram_addr, 3) + 11'h001))
		else $error("SRAM copy skipped a row");
	a_otp_lock: assert property (@(posedge clk) disable iff (!rst_n)
		otp_ext_grant |-> !sec_r.master_lock && !sec_r.sector_lock[$past(otp_ext_sector)])
		else $error("OTP access granted while locked");
	a_idle_low: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		$rose(link_lines_oe) |-> $past(len_q2) && !link_line_16 && !link_line_17)
		else $error("link idle lines not low");

endmodule

// >>> bsl_far_model.sv
// Far-side model: OTP array, SPI boot flash and link peer
`timescale 1ns/100ps
module bsl_far_model #(
	parameter logic [31:0] FLASH_WORD = 32'h96C3_5AF0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic otp_rd_en,
	input wire logic [10:0] otp_rd_addr,
	output logic [31:0] otp_rd_data,
	input wire logic [9:0] sec_word,
	input wire logic spi_sel_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic [31:0] spi_cmd,
	output logic [10:0] first_addr,
	input wire logic [1:0] link_go,
	output logic line_19,
	output logic line_20
);
	import bsl_pkg::*;
	logic seen;
	int cnt;

	// ********************************
	// OTP array
	// ********************************
	// Data valid the cycle after the read strobe; otherwise it changes every cycle
	always_ff @(posedge clk) begin
		if (otp_rd_en)
			otp_rd_data <= (otp_rd_addr == SEC_ROW) ? {22'h0, sec_word} :
				{16'hC35A, 5'h00, otp_rd_addr};
		else
			otp_rd_data <= ~otp_rd_data;
	end

	// Remember which row is read first after each reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 1'b0;
			first_addr <= 11'h000;
		end else if (otp_rd_en && !seen) begin
			seen <= 1'b1;
			first_addr <= otp_rd_addr;
		end
	end

	// ********************************
	// SPI flash
	// ********************************
	// Command captured on rising clock; reply shifts on falling, MSB first
	initial spi_miso = 1'b0;
	always @(posedge spi_sclk or posedge spi_sel_n) begin
		if (spi_sel_n) begin
			cnt <= 0;
		end else begin
			if (cnt < 32)
				spi_cmd <= {spi_cmd[30:0], spi_mosi};
			cnt <= cnt + 1;
		end
	end
	// Deselected flash inverts the line once as select rises, not holding its last bit
	always @(negedge spi_sclk or posedge spi_sel_n) begin
		if (spi_sel_n)
			spi_miso <= ~spi_miso;
		else if (cnt >= 32)
			spi_miso <= FLASH_WORD[31 - ((cnt - 32) % 32)];
	end

	// ********************************
	// Link peer
	// ********************************
	// Both watched lines stay low until the bench starts traffic; each line has its own start
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_19 <= 1'b0;
			line_20 <= 1'b0;
		end else begin
			line_19 <= link_go[0];
			line_20 <= link_go[1];
		end
	end
endmodule

// >>> bsl_loader_bench.sv
// Self-checking bench for the boot source and security loader
`timescale 1ns/100ps
module bsl_loader_bench;
	import bsl_pkg::*;
	typedef struct packed {
		logic [2:0] sel;
		logic [9:0] sec;
		bsl_src_t t0;
		bsl_src_t t1;
	} bsl_row_t;
	localparam logic [31:0] PAT = 32'h96C3_5AF0;
	logic clk, rst_n, link_clk, rlo, rhi, miso, l19, l20, sw_req, dbg_n, oreq;
	logic [1:0] go;
	logic [2:0] sel;
	logic [1:0] osec;
	logic [9:0] sec;
	logic otp_en, wr_en, pull, rbp, done, ss, sclk, mosi, soe, sval, lben, ilen, pden;
	logic l16, l17, loe, ltr, jen, sgnt, dreq, ognt;
	logic [10:0] oaddr, waddr, first_addr;
	logic [31:0] odata, wdata, sword, spi_cmd;
	logic [1:0] ratio;
	bsl_src_t t0, t1;
	int checks, fail_count, wr_cnt, bad, cyc;
	bsl_row_t rows [8] = '{
		'{3'h0, 10'h000, SRC_NONE, SRC_NONE}, '{3'h4, 10'h001, SRC_NONE, SRC_NONE},
		'{3'h1, 10'h000, SRC_NONE, SRC_NONE}, '{3'h2, 10'h002, SRC_LINKB, SRC_CE0},
		'{3'h3, 10'h004, SRC_SPI, SRC_CE0}, '{3'h6, 10'h008, SRC_CE0, SRC_CE0},
		'{3'h7, 10'h100, SRC_SPI, SRC_SPI}, '{3'h3, 10'h020, SRC_OTP, SRC_OTP}};

	bsl_loader dut_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.clock_ratio_sel_lo(rlo), .clock_ratio_sel_hi(rhi), .boot_sel_pins(sel),
		.otp_rd_data(odata), .otp_rd_en(otp_en), .otp_rd_addr(oaddr), .sram_wr_en(wr_en),
		.sram_addr(waddr), .sram_wr_data(wdata), .gpio_pull_en(pull), .clk_ratio(ratio),
		.tile_zero_src(t0), .tile_one_src(t1), .rom_bypass(rbp), .loader_done(done),
		.spi_boot_miso_pin(miso), .spi_boot_select_pin(ss), .spi_boot_clock_pin(sclk),
		.spi_boot_mosi_pin(mosi), .spi_pins_oe(soe), .spi_word(sword), .spi_word_valid(sval),
		.link_b_en(lben), .int_links_en(ilen), .link_pulldown_en(pden), .link_line_16(l16),
		.link_line_17(l17), .link_lines_oe(loe), .link_line_19(l19), .link_line_20(l20),
		.link_traffic(ltr), .jtag_access_en(jen), .sw_access_req(sw_req),
		.sw_access_grant(sgnt), .debug_sync_n(dbg_n), .debug_req(dreq),
		.otp_ext_req(oreq), .otp_ext_sector(osec), .otp_ext_grant(ognt));

	bsl_far_model #(.FLASH_WORD(PAT)) far_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.otp_rd_en(otp_en), .otp_rd_addr(oaddr), .otp_rd_data(odata), .sec_word(sec),
		.spi_sel_n(ss), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
		.spi_cmd(spi_cmd), .first_addr(first_addr), .link_go(go), .line_19(l19),
		.line_20(l20));

	// ********************************
	// Clocks, monitors, helpers
	// ********************************
	// Link clock offset so its edges never line up with the system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// Copy writes must climb by one row and carry that row's contents
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			fail_count++;
			end_of_test;
		end
		if (rst_n && wr_en === 1'b1) begin
			if (waddr !== wr_cnt[10:0] || wdata !== {16'hC35A, 5'h00, waddr})
				bad++;
			wr_cnt++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Inputs move one time unit after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic end_of_test;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One full boot per row: reset, reset process, copy, then per-source checks
	task automatic boot(input int i);
		int n;
		logic lk;
		rst_n = 1'b0;
		sel = rows[i].sel;
		sec = rows[i].sec;
		{rhi, rlo} = i[1:0];
		go = 2'h0;
		wr_cnt = 0;
		bad = 0;
		lk = (rows[i].t0 == SRC_LINKB || rows[i].t0 == SRC_CE0);
		tick(10);
		chk({soe, loe, pull, done}, 0);
		rst_n = 1'b1;
		for (n = 0; n < 1600 && pull !== 1'b1; n++) tick(1);
		chk(n, RST_PROC_CYC);
		for (n = 0; n < 7000 && done !== 1'b1; n++) tick(1);
		chk(t0, rows[i].t0);
		chk(t1, rows[i].t1);
		chk(rbp, sec[5]);
		chk(ratio, i[1:0]);
		tick(3);
		chk(jen, !sec[0]);
		chk(wr_cnt, 2047);
		chk(bad, 0);
		chk(first_addr, SEC_ROW);
		sw_req = 1'b1;
		oreq = 1'b1;
		osec = i[1:0];
		tick(1);
		chk(sgnt, !sec[1]);
		chk(ognt, !(sec[3] | sec[6 + i[1:0]]));
		sw_req = 1'b0;
		oreq = 1'b0;
		dbg_n = 1'b0;
		tick(5);
		chk(dreq, !sec[2]);
		dbg_n = 1'b1;
		tick(9);
		chk(lben, 0);
		tick(2);
		chk(lben, lk);
		tick(10);
		chk(ilen, rows[i].sel == SEL_CE0 && !sec[5]);
		if (lk) begin
			chk({pden, loe, l16, l17}, 4'h4);
			chk(ltr, 0);
			go = (i == 3) ? 2'h1 : 2'h2;
			tick(12);
			chk(ltr, 1);
		end
		if (rows[i].t0 == SRC_SPI || rows[i].t1 == SRC_SPI) begin
			chk({soe, ss}, 2'h2);
			for (n = 0; n < 100 && sclk !== 1'b0; n++) tick(1);
			for (n = 0; n < 100 && sclk !== 1'b1; n++) tick(1);
			for (n = 0; n < 100 && sclk !== 1'b0; n++) tick(1);
			chk(n, SPI_HALF_CYC);
			for (n = 0; n < 3000 && sval !== 1'b1; n++) tick(1);
			chk(spi_cmd, SPI_READ_CMD);
			chk(sword, PAT);
		end
		sel = ~sel;
		{rhi, rlo} = ~i[1:0];
		tick(5);
		chk({t0, ratio}, {rows[i].t0, i[1:0]});
		$display("test %0d done", i);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rst_n = 1'b0;
		{sel, sec, rlo, rhi, osec} = '0;
		{sw_req, oreq, go} = 4'h0;
		dbg_n = 1'b1;
		{checks, fail_count, wr_cnt, bad, cyc} = '0;
		#1;
		for (int i = 0; i < 8; i++)
			boot(i);
		// Reset in mid-run clears the decision and the pins at once
		rst_n = 1'b0;
		tick(1);
		chk({done, soe, loe, pull, rbp}, 0);
		$display("test mid-run reset done");
		end_of_test;
	end
endmodule
